// ===== bench/csa_top_bench.sv
// Self-checking testbench for the comparator status aggregator
`timescale 1ns/1ns
`default_nettype none
module csa_top_bench
  import csa_pkg::*;
;
  logic mclk, nrst, hsel, hwrite, hready, hreadyout, hresp, idle_mode, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [4:0] cmp_raw, trigger, opamp_active;
  int err_total;
  int compares;
  assign hready = hreadyout;
  csa_top dut (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CMP_RAW(cmp_raw), .IDLE_MODE(idle_mode),
    .TRIGGER(trigger), .OPAMP_ACTIVE(opamp_active), .IRQ(irq));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // One single-word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= CSA_HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  function automatic logic [7:0] cha(input int n);
    return CSA_OFS_CH_BASE + 8'(4 * (n - 1));
  endfunction
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask
  task automatic raw(input logic [4:0] v);
    @(posedge mclk);
    cmp_raw <= v;
    settle();
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk("hreadyout", 32'h0000_0001, 32'(hreadyout));
    chk("hresp", 32'h0000_0000, 32'(hresp));
    chk("irq", 32'h0000_0000, 32'(irq));
    rdchk("summary", CSA_OFS_SUMMARY, 32'h0000_0000);
    rdchk("ch5 word", cha(5), 32'h0000_0000);
    rdchk("mask", CSA_OFS_IRQ_MASK, 32'h0000_0000);
  endtask
  task automatic t_idle_bit();
    wr(CSA_OFS_SUMMARY, 32'hFFFF_FFFF);
    rdchk("summary rw", CSA_OFS_SUMMARY, 32'h0000_8000);
    wr(CSA_OFS_SUMMARY, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
  endtask
  task automatic t_events();
    for (int n = 1; n <= 5; n++) begin
      wr(cha(n), 32'h0000_8040);
    end
    @(posedge mclk);
    cmp_raw <= 5'h1F;
    @(posedge mclk);
    #1 chk("trigger", 32'h0000_001F, 32'(trigger));
    settle();
    rdchk("summary", CSA_OFS_SUMMARY, 32'h0000_1F1F);
    rdchk("ch3 word", cha(3), 32'h0000_8340);
    raw(5'h00);
    rdchk("sticky", CSA_OFS_SUMMARY, 32'h0000_1F00);
    wr(cha(1), 32'h0000_8040);
    wr(cha(2), 32'h0000_A040);
    settle();
    rdchk("cleared", CSA_OFS_SUMMARY, 32'h0000_1E02);
  endtask
  task automatic t_edges();
    logic [31:0] base;
    for (int e = 0; e < 4; e++) begin
      base = 32'h0000_8000 | (32'(e) << 6);
      wr(cha(1), base);
      raw(5'h01);
      rdchk("after rise", cha(1), base | 32'h0000_0100 | (e[0] ? 32'h0000_0200 : 0));
      raw(5'h00);
      rdchk("after fall", cha(1), base | (e != 0 ? 32'h0000_0200 : 0));
    end
  endtask
  task automatic t_opamp_idle();
    for (int n = 1; n <= 5; n++) begin
      wr(cha(n), 32'h0000_8440);
    end
    settle();
    chk("opamp", 32'h0000_0017, 32'(opamp_active));
    rdchk("ch4 word", cha(4), 32'h0000_8040);
    wr(CSA_OFS_SUMMARY, 32'h0000_8000);
    @(posedge mclk);
    idle_mode <= 1'b1;
    raw(5'h1F);
    chk("idle opamp", 32'h0000_0000, 32'(opamp_active));
    rdchk("idle frozen", CSA_OFS_SUMMARY, 32'h0000_8000);
    wr(CSA_OFS_SUMMARY, 32'h0000_0000);
    settle();
    bus(1'b0, CSA_OFS_SUMMARY, 32'h0000_0000);
    chk("idle running", 32'h0000_001F, rd & 32'h0000_001F);
    @(posedge mclk);
    idle_mode <= 1'b0;
  endtask
  task automatic t_irq();
    wr(CSA_OFS_IRQ_MASK, 32'h0000_0000);
    raw(5'h00);
    wr(CSA_OFS_IRQ_STATUS, 32'hFFFF_FFFF);
    raw(5'h01);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(CSA_OFS_IRQ_MASK, 32'h0000_001F);
    settle();
    chk("irq raised", 32'h0000_0001, 32'(irq));
    wr(CSA_OFS_IRQ_STATUS, 32'hFFFF_FFFF);
    settle();
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    rdchk("status", CSA_OFS_IRQ_STATUS, 32'h0000_0000);
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    cmp_raw = 5'h00;
    idle_mode = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_idle_bit();
    t_events();
    t_edges();
    t_opamp_idle();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== design/csa_channel.sv
// One comparator channel: polarity, edge detect, sticky event latch
`timescale 1ns/1ns
`default_nettype none
module csa_channel
  import csa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire csa_chcfg_type cfg,
  input wire logic clr_evt,
  // Analogue result
  input wire logic raw,
  // Status
  output logic out_reg,
  output logic evt_reg,
  output logic trig_reg
);
  logic out_next;
  logic rise;
  logic fall;
  logic hit;

  always_comb begin
    out_next = cfg.enable & (raw ^ cfg.invert);
    rise = out_next & ~out_reg;
    fall = ~out_next & out_reg;
    unique case (cfg.edge_sel)
      CSA_EDGE_RISE: hit = run & rise;
      CSA_EDGE_FALL: hit = run & fall;
      CSA_EDGE_BOTH: hit = run & (rise | fall);
      CSA_EDGE_NONE: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output value, frozen while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (run) begin
      out_reg <= out_next;
    end
  end

  // Trigger pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= hit;
    end
  end

  // Sticky event, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= 1'b0;
    end else if (hit) begin
      evt_reg <= 1'b1;
    end else if (clr_evt) begin
      evt_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rise_hit;
    run && cfg.edge_sel == CSA_EDGE_RISE && !out_reg && out_next;
  endsequence

  a_rise_event: assert property (@(posedge clk) disable iff (!rst_n)
    s_rise_hit |=> trig_reg && evt_reg ##1 !trig_reg || $past(hit))
    else $error("rising edge did not raise trigger and event");
  a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    evt_reg && !clr_evt |=> evt_reg)
    else $error("event flag dropped without clear");
  a_event_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clr_evt && !hit |=> !evt_reg)
    else $error("event flag not cleared");
  a_out_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    run |=> out_reg == $past(cfg.enable & (raw ^ cfg.invert)))
    else $error("output flag ignores polarity");
  a_halt_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> $stable(out_reg) && !trig_reg)
    else $error("halted channel changed");
endmodule
`default_nettype wire

// ===== design/csa_pkg.sv
// Package: register map, field positions and types of the comparator status block
package csa_pkg;
  localparam int CSA_CH_MAX = 5;
  // Register byte offsets
  localparam logic [7:0] CSA_OFS_SUMMARY = 8'h00;
  localparam logic [7:0] CSA_OFS_CH_BASE = 8'h04;
  localparam logic [7:0] CSA_OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] CSA_OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] CSA_OFS_CH_LAST = 8'h14;
  // Summary word fields
  localparam int CSA_SUM_IDLE_BIT = 15;
  localparam int CSA_SUM_EVT_LSB = 8;
  localparam int CSA_SUM_OUT_LSB = 0;
  localparam logic [15:0] CSA_SUM_RESERVED = 16'h60E0;
  // Channel control word fields
  localparam int CSA_CTL_EN_BIT = 15;
  localparam int CSA_CTL_INV_BIT = 13;
  localparam int CSA_CTL_OPA_BIT = 10;
  localparam int CSA_CTL_EVT_BIT = 9;
  localparam int CSA_CTL_OUT_BIT = 8;
  localparam int CSA_CTL_EDGE_LSB = 6;
  // Channels that may run as op amps: one, two, three, five
  localparam logic [4:0] CSA_OPAMP_CAPABLE = 5'h17;
  // Bus codes
  localparam logic [1:0] CSA_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CSA_HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {CSA_EDGE_NONE, CSA_EDGE_RISE, CSA_EDGE_FALL, CSA_EDGE_BOTH}
    csa_edge_type;

  typedef struct packed {
    logic enable;
    logic invert;
    logic opamp;
    csa_edge_type edge_sel;
  } csa_chcfg_type;
endpackage

// ===== design/csa_top.sv
// Comparator status aggregator: AHB-Lite registers, channels, interrupt
`timescale 1ns/1ns
`default_nettype none
module csa_top
  import csa_pkg::*;
#(
  parameter int NUM_CH = CSA_CH_MAX
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Analogue side
  input wire logic [CSA_CH_MAX-1:0] CMP_RAW,
  input wire logic IDLE_MODE,
  // Results
  output logic [CSA_CH_MAX-1:0] TRIGGER,
  output logic [CSA_CH_MAX-1:0] OPAMP_ACTIVE,
  output logic IRQ
);
  // Channel count must fit the fixed port width
  if (NUM_CH < 1 || NUM_CH > CSA_CH_MAX) begin : g_bad_num_ch
    $error("NUM_CH out of range");
  end

  logic idle_stop_select_reg;
  csa_chcfg_type cfg_reg [CSA_CH_MAX];
  logic [CSA_CH_MAX-1:0] channel_event_flags;
  logic [CSA_CH_MAX-1:0] channel_output_flags;
  logic [CSA_CH_MAX-1:0] irq_status_reg;
  logic [CSA_CH_MAX-1:0] irq_mask_reg;
  logic [CSA_CH_MAX-1:0] clr_evt;
  logic [CSA_CH_MAX-1:0] opamp_next;
  logic [15:0] summary;
  logic run;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic addr_take;
  logic [31:0] rdata_next;
  logic [7:0] haddr_low;
  logic wr_summary;
  logic wr_status;
  logic wr_mask;
  logic [CSA_CH_MAX-1:0] wr_ch;

  assign haddr_low = HADDR[7:0];
  assign addr_take = HSEL && HREADY && (HTRANS == CSA_HTRANS_NONSEQ || HTRANS == CSA_HTRANS_SEQ);
  assign run = !(idle_stop_select_reg && IDLE_MODE);

  ////////////////////////////////////////////////////////////////////////
  // Channels
  genvar gi;
  generate
    for (gi = 0; gi < CSA_CH_MAX; gi++) begin : g_ch
      if (gi < NUM_CH) begin : g_on
        csa_channel u_ch (
          .clk(MCLK),
          .rst_n(NRST),
          .run(run),
          .cfg(cfg_reg[gi]),
          .clr_evt(clr_evt[gi]),
          .raw(CMP_RAW[gi]),
          .out_reg(channel_output_flags[gi]),
          .evt_reg(channel_event_flags[gi]),
          .trig_reg(TRIGGER[gi])
        );
      end else begin : g_off
        assign channel_output_flags[gi] = 1'b0;
        assign channel_event_flags[gi] = 1'b0;
        assign TRIGGER[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    summary = 16'h0000;
    summary[CSA_SUM_IDLE_BIT] = idle_stop_select_reg;
    summary[CSA_SUM_EVT_LSB +: CSA_CH_MAX] = channel_event_flags;
    summary[CSA_SUM_OUT_LSB +: CSA_CH_MAX] = channel_output_flags;
    opamp_next = '0;
    for (int i = 0; i < CSA_CH_MAX; i++) begin
      opamp_next[i] = run && (i < NUM_CH) && CSA_OPAMP_CAPABLE[i]
        && cfg_reg[i].enable && cfg_reg[i].opamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase and read data
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (haddr_low == CSA_OFS_SUMMARY) begin
      rdata_next[15:0] = summary;
    end else if (haddr_low == CSA_OFS_IRQ_STATUS) begin
      rdata_next[CSA_CH_MAX-1:0] = irq_status_reg;
    end else if (haddr_low == CSA_OFS_IRQ_MASK) begin
      rdata_next[CSA_CH_MAX-1:0] = irq_mask_reg;
    end
    for (int i = 0; i < CSA_CH_MAX; i++) begin
      if (haddr_low == CSA_OFS_CH_BASE + 8'(4 * i)) begin
        rdata_next[CSA_CTL_EN_BIT] = cfg_reg[i].enable;
        rdata_next[CSA_CTL_INV_BIT] = cfg_reg[i].invert;
        rdata_next[CSA_CTL_OPA_BIT] = cfg_reg[i].opamp;
        rdata_next[CSA_CTL_EVT_BIT] = channel_event_flags[i];
        rdata_next[CSA_CTL_OUT_BIT] = channel_output_flags[i];
        rdata_next[CSA_CTL_EDGE_LSB +: $bits(csa_edge_type)] = cfg_reg[i].edge_sel;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY) begin
        wr_pend_reg <= addr_take && HWRITE;
        addr_reg <= haddr_low;
        if (addr_take && !HWRITE) begin
          HRDATA <= rdata_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data phase writes
  always_comb begin
    wr_summary = wr_pend_reg && addr_reg == CSA_OFS_SUMMARY;
    wr_status = wr_pend_reg && addr_reg == CSA_OFS_IRQ_STATUS;
    wr_mask = wr_pend_reg && addr_reg == CSA_OFS_IRQ_MASK;
    for (int i = 0; i < CSA_CH_MAX; i++) begin
      wr_ch[i] = wr_pend_reg && addr_reg == CSA_OFS_CH_BASE + 8'(4 * i);
      clr_evt[i] = wr_ch[i] && !HWDATA[CSA_CTL_EVT_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      idle_stop_select_reg <= 1'b0;
    end else if (wr_summary) begin
      idle_stop_select_reg <= HWDATA[CSA_SUM_IDLE_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < CSA_CH_MAX; i++) begin
        cfg_reg[i] <= '{enable: 1'b0, invert: 1'b0, opamp: 1'b0, edge_sel: CSA_EDGE_NONE};
      end
    end else begin
      for (int i = 0; i < CSA_CH_MAX; i++) begin
        if (wr_ch[i]) begin
          cfg_reg[i].enable <= HWDATA[CSA_CTL_EN_BIT];
          cfg_reg[i].invert <= HWDATA[CSA_CTL_INV_BIT];
          cfg_reg[i].opamp <= HWDATA[CSA_CTL_OPA_BIT] & CSA_OPAMP_CAPABLE[i];
          cfg_reg[i].edge_sel <=
            csa_edge_type'(HWDATA[CSA_CTL_EDGE_LSB +: $bits(csa_edge_type)]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      IRQ <= 1'b0;
      OPAMP_ACTIVE <= '0;
    end else begin
      irq_status_reg <= TRIGGER |
        (irq_status_reg & ~(wr_status ? HWDATA[CSA_CH_MAX-1:0] : '0));
      if (wr_mask) begin
        irq_mask_reg <= HWDATA[CSA_CH_MAX-1:0];
      end
      IRQ <= |(irq_status_reg & irq_mask_reg);
      OPAMP_ACTIVE <= opamp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_summary_reserved: assert property (@(posedge MCLK) disable iff (!NRST)
    addr_take && !HWRITE && haddr_low == CSA_OFS_SUMMARY
    |=> (HRDATA[15:0] & CSA_SUM_RESERVED) == 16'h0000 && HRDATA[31:16] == 16'h0000)
    else $error("reserved summary bits read nonzero");
  a_summary_mirror: assert property (@(posedge MCLK) disable iff (!NRST)
    addr_take && !HWRITE && haddr_low == CSA_OFS_SUMMARY
    |=> HRDATA[CSA_SUM_EVT_LSB +: CSA_CH_MAX] == $past(channel_event_flags)
      && HRDATA[CSA_SUM_OUT_LSB +: CSA_CH_MAX] == $past(channel_output_flags))
    else $error("summary does not mirror channel flags");
  a_idle_write: assert property (@(posedge MCLK) disable iff (!NRST)
    wr_summary |=> idle_stop_select_reg == $past(HWDATA[CSA_SUM_IDLE_BIT]))
    else $error("idle-stop bit not written");
  a_idle_halt: assert property (@(posedge MCLK) disable iff (!NRST)
    idle_stop_select_reg && IDLE_MODE |=> OPAMP_ACTIVE == '0 && TRIGGER == '0)
    else $error("channels run in idle with stop set");
  a_irq_level: assert property (@(posedge MCLK) disable iff (!NRST)
    1'b1 |=> IRQ == $past(|(irq_status_reg & irq_mask_reg)))
    else $error("interrupt does not follow status and mask");
  a_bus_okay: assert property (@(posedge MCLK) disable iff (!NRST)
    HREADYOUT && !HRESP)
    else $error("slave stalled or errored");
endmodule
`default_nettype wire
